// *** hw/gate_drv_logic.sv ***
// What this block does
// - Comparator trip reaches timer break whatever the select, except in standby
// - Select low: comparator goes only to timer
// - Select high: comparator also to driver
// - Selected trip forces all high-side outputs low
// - Blanking latched until all-low then rising edge
// - Both inputs high: both outputs low
// - Standby both low: outputs low after delay
`default_nettype none
module gate_drv_logic
    import gate_drv_pkg::*;
#(
    parameter int SLEEP_COUNT = SLEEP_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    input wire gate_pair_s pwm_in,
    input wire logic overcurrent_sense_input,
    input wire logic overcurrent_action_select,
    input wire logic standby_request_n_a,
    input wire logic standby_request_n_b,
    output logic timer_break_input,
    output gate_pair_s gate_out,
    output logic comparator_enabled
);

    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------
    // Parameter checks
    // ----------------------------------------
    // The carrier struct is fixed, so PHASES cannot grow alone
    initial
    begin
        if (SLEEP_COUNT < 1 || SLEEP_COUNT >= (1 << SLEEP_CNT_W))
            $error("SLEEP_COUNT out of range");
        if (PHASES < 1)
            $error("PHASES must be at least 1");
        if ($bits(gate_pair_s) != 2 * PHASES)
            $error("gate_pair_s does not match PHASES");
    end

    // ----------------------------------------
    // State record
    // ----------------------------------------
    // Counter width limits how long the sleep delay can be
    localparam logic [SLEEP_CNT_W-1:0] SLEEP_LAST =
        SLEEP_CNT_W'(SLEEP_COUNT - 1);
    localparam logic [SLEEP_CNT_W-1:0] SLEEP_STEP = SLEEP_CNT_W'(1);

    typedef struct packed {
        power_state_e pwr;
        logic [SLEEP_CNT_W-1:0] sleep_cnt;
        logic brk;
        gate_pair_s out;
        logic cmp_en;
    } core_state_s;

    core_state_s state_reg;
    core_state_s state_next;

    // ----------------------------------------
    // Internal nets
    // ----------------------------------------
    logic blanking;
    logic oc_live;
    logic oc_to_driver;
    logic standby_req;
    logic sleep_done;
    logic drive_allowed;

    logic [PHASES-1:0] phase_both;
    logic [PHASES-1:0] high_gated;
    logic [PHASES-1:0] low_gated;

    // ----------------------------------------
    // Overcurrent routing
    // ----------------------------------------
    // Comparator is dead in standby, so events are masked there
    assign oc_live = overcurrent_sense_input && state_reg.cmp_en;
    // Select low keeps the trip away from the gates
    assign oc_to_driver = oc_live && overcurrent_action_select;

    // ----------------------------------------
    // Standby request
    // ----------------------------------------
    // Both lines must be low, so one stray line cannot sleep the gates
    assign standby_req = !standby_request_n_a && !standby_request_n_b;
    assign sleep_done = (state_reg.sleep_cnt == SLEEP_LAST);
    assign drive_allowed = (state_reg.pwr != ST_STANDBY);

    // ----------------------------------------
    // Blanking latch
    // ----------------------------------------
    // Held apart so the release sequence can be tested on its own
    oc_blank_latch #(
        .WIDTH(PHASES)
    ) u_blank (
        .clk(clk),
        .rst(rst),
        .oc_event(oc_to_driver),
        .high_side_in(pwm_in.high_side),
        .blanking(blanking)
    );

    // ----------------------------------------
    // Per-phase gating
    // ----------------------------------------
    // The live trip gates too, so the first blanked cycle is not late
    // Interlock wins over both inputs of a phase
    for (genvar i = 0; i < PHASES; i++)
    begin : g_phase
        assign phase_both[i] = pwm_in.high_side[i] && pwm_in.low_side[i];
        assign high_gated[i] = pwm_in.high_side[i]
            && !phase_both[i]
            && !blanking
            && !oc_to_driver
            && drive_allowed;
        assign low_gated[i] = pwm_in.low_side[i]
            && !phase_both[i]
            && drive_allowed;
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    // Outputs follow during the sleep wait; only standby forces them
    always_comb
    begin
        state_next = state_reg;
        // Break copies the live trip whatever the select says
        state_next.brk = oc_live;
        state_next.out.high_side = high_gated;
        state_next.out.low_side = low_gated;

        unique case (state_reg.pwr)
            ST_RUN:
            begin
                // A new request restarts the sleep count
                state_next.cmp_en = 1'b1;
                if (standby_req)
                begin
                    state_next.pwr = ST_SLEEP_WAIT;
                    state_next.sleep_cnt = '0;
                end
            end

            ST_SLEEP_WAIT:
            begin
                // Releasing either line aborts the wait
                if (!standby_req)
                begin
                    state_next.pwr = ST_RUN;
                end
                else if (sleep_done)
                begin
                    state_next.pwr = ST_STANDBY;
                    state_next.cmp_en = 1'b0;
                end
                else
                begin
                    state_next.sleep_cnt = state_reg.sleep_cnt + SLEEP_STEP;
                end
            end

            ST_STANDBY:
            begin
                // Comparator wakes here; the gates drive again one cycle later
                if (!standby_req)
                begin
                    state_next.pwr = ST_RUN;
                    state_next.cmp_en = 1'b1;
                end
            end

            default:
            begin
                // Unused code: fall back to run
                state_next.pwr = ST_RUN;
                state_next.cmp_en = 1'b1;
            end
        endcase
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Reset holds every gate low, as if all inputs were low
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg.pwr <= ST_RUN;
            state_reg.sleep_cnt <= '0;
            state_reg.brk <= 1'b0;
            state_reg.out.high_side <= PHASE_OFF;
            state_reg.out.low_side <= PHASE_OFF;
            state_reg.cmp_en <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // All outputs come straight from the state register
    assign timer_break_input = state_reg.brk;
    assign gate_out = state_reg.out;
    assign comparator_enabled = state_reg.cmp_en;

endmodule : gate_drv_logic
`default_nettype wire

// *** hw/oc_blank_latch.sv ***
`default_nettype none
module oc_blank_latch
    import gate_drv_pkg::*;
#(
    parameter int WIDTH = PHASES
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic oc_event,
    input wire logic [WIDTH-1:0] high_side_in,
    output logic blanking
);
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic blank;
        logic all_low_seen;
        logic [WIDTH-1:0] hs_prev;
    } latch_state_s;

    latch_state_s state_reg;
    latch_state_s state_next;

    initial
    begin
        if (WIDTH < 1) $error("WIDTH must be at least 1");
    end

    // ----------------------------------------
    // Latch: set on event, release on rising edge after all-low
    // ----------------------------------------
    always_comb
    begin
        state_next = state_reg;
        state_next.hs_prev = high_side_in;
        if (oc_event)
        begin
            // Event wins over any release in the same cycle
            state_next.blank = 1'b1;
            state_next.all_low_seen = 1'b0;
        end
        else if (state_reg.blank)
        begin
            if (state_reg.all_low_seen
                && ((high_side_in & ~state_reg.hs_prev) != '0))
            begin
                state_next.blank = 1'b0;
                state_next.all_low_seen = 1'b0;
            end
            else if (high_side_in == '0)
            begin
                state_next.all_low_seen = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign blanking = state_reg.blank;

endmodule : oc_blank_latch
`default_nettype wire

// *** inc/gate_drv_pkg.sv ***
`default_nettype none
package gate_drv_pkg;
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------
    // Sizes and timing
    // ----------------------------------------
    localparam int PHASES = 3;
    localparam int CLK_PERIOD_NS = 40;
    // Sleep delay before standby takes the outputs down (time in ns)
    localparam int SLEEP_DELAY_NS = 4000;
    localparam int SLEEP_CYCLES = SLEEP_DELAY_NS / CLK_PERIOD_NS;
    localparam int SLEEP_CNT_W = 16;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [2:0] PHASE_OFF = 3'h0;
    localparam logic OC_ACTION_DEFAULT = 1'b0;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic [2:0] high_side;
        logic [2:0] low_side;
    } gate_pair_s;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_SLEEP_WAIT,
        ST_STANDBY
    } power_state_e;

endpackage : gate_drv_pkg
`default_nettype wire

// *** test/gate_drv_asserts.sv ***
`default_nettype none
module gate_drv_asserts
    import gate_drv_pkg::*;
#(
    parameter int SLEEP_COUNT = SLEEP_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    input wire gate_pair_s pwm_in,
    input wire logic overcurrent_sense_input,
    input wire logic overcurrent_action_select,
    input wire logic standby_request_n_a,
    input wire logic standby_request_n_b,
    input wire logic timer_break_input,
    input wire gate_pair_s gate_out,
    input wire logic comparator_enabled
);
    timeunit 1ns;
    timeprecision 1ns;
    wire logic sen = overcurrent_sense_input;
    wire logic sel = overcurrent_action_select;
    wire logic run = standby_request_n_a;
    wire logic [2:0] ho = gate_out.high_side;
    int nap;
    always_ff @(posedge clk)
        nap <= (rst || run || standby_request_n_b) ? 0 : nap + 1;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_trip;
        sel && sen && comparator_enabled;
    endsequence
    sequence s_rise;
        (!sen && pwm_in == 6'h38 && run)[*3];
    endsequence
    chk_break_follows:
        assert property (sen && comparator_enabled ##1 comparator_enabled
            |-> timer_break_input) else $error("break missing");
    chk_break_quiet:
        assert property (!sen |=> !timer_break_input)
            else $error("break without trip");
    chk_trip_blanks:
        assert property (s_trip |=> ho == 3'h0) else $error("not blanked");
    chk_blank_holds:
        assert property (s_trip ##1 (pwm_in.high_side != 3'h0)[*3]
            |-> ho == 3'h0) else $error("blank lost");
    chk_rearm_follows:
        assert property ((!sen && pwm_in == 6'h0 && run) ##1 s_rise
            |-> ho == 3'h7) else $error("no rearm");
    chk_select_off:
        assert property ((!sel && !sen && pwm_in == 6'h0 && run) ##1
            (!sel && pwm_in == 6'h38 && run)[*3] |-> ho == 3'h7)
            else $error("blanked while off");
    chk_phase_lock:
        assert property (((ho | gate_out.low_side) & $past(pwm_in.high_side
            & pwm_in.low_side)) == 3'h0) else $error("both sides on");
    chk_follow_only:
        assert property ((gate_out & ~$past(pwm_in)) == 6'h0)
            else $error("output without input");
    chk_standby_off:
        assert property (nap >= SLEEP_COUNT + 2 |-> gate_out == 6'h0
            && !comparator_enabled) else $error("awake in standby");
endmodule : gate_drv_asserts
bind gate_drv_logic gate_drv_asserts #(.SLEEP_COUNT(SLEEP_COUNT)) chk (
    .clk(clk),
    .rst(rst),
    .pwm_in(pwm_in),
    .overcurrent_sense_input(overcurrent_sense_input),
    .overcurrent_action_select(overcurrent_action_select),
    .standby_request_n_a(standby_request_n_a),
    .standby_request_n_b(standby_request_n_b),
    .timer_break_input(timer_break_input),
    .gate_out(gate_out),
    .comparator_enabled(comparator_enabled)
);
`default_nettype wire

// *** test/pwm_timer_model.sv ***
`default_nettype none
module pwm_timer_model
    import gate_drv_pkg::*;
(
    input wire logic clk,
    input wire logic [2:0] cmd,
    input wire logic overlap,
    output gate_pair_s pwm
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cmd_reg;
    always_ff @(posedge clk)
        cmd_reg <= cmd;
    // One cycle dead on each command edge; overlap is a deliberate fault
    assign pwm = {cmd & cmd_reg, (~cmd & ~cmd_reg) | {3{overlap}}};
endmodule : pwm_timer_model
`default_nettype wire

// *** test/tb_top.sv ***
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SLP = 4;
    logic clk = 1'b0, rst = 1'b1, sen = 1'b0, lap = 1'b0;
    logic sel = gate_drv_pkg::OC_ACTION_DEFAULT;
    logic na = 1'b1, nb = 1'b1, brk, cen;
    logic [2:0] cmd = 3'h0;
    gate_drv_pkg::gate_pair_s pwm, go;
    int n_errors = 0, checked = 0, cycles = 0;
    pwm_timer_model tmr (.clk, .cmd, .overlap(lap), .pwm);
    gate_drv_logic #(.SLEEP_COUNT(SLP)) dut (.clk, .rst, .pwm_in(pwm),
        .overcurrent_sense_input(sen), .overcurrent_action_select(sel),
        .standby_request_n_a(na), .standby_request_n_b(nb),
        .timer_break_input(brk), .gate_out(go), .comparator_enabled(cen));
    initial
        forever #20 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles > 500)
        begin
            n_errors++;
            final_report();
        end
    end
    task automatic cyc(int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic check(string s, logic [7:0] seen, logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s exp %h seen %h", s, exp, seen);
        end
    endtask : check
    task automatic final_report();
        if (n_errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report
    task automatic t_select_off();
        cmd = 3'h7;
        cyc(2);
        sen = 1'b1;
        cyc(3);
        check("brk", {7'h00, brk}, 8'h01);
        check("gate", {2'h0, go}, 8'h38);
        sen = 1'b0;
        cyc(1);
    endtask : t_select_off
    task automatic t_trip();
        sel = 1'b1;
        sen = 1'b1;
        cyc(1);
        check("brk", {7'h00, brk}, 8'h01);
        check("blank", {2'h0, go}, 8'h00);
        sen = 1'b0;
        cyc(4);
        check("hold", {2'h0, go}, 8'h00);
        cmd = 3'h0;
        cyc(2);
        cmd = 3'h7;
        cyc(4);
        check("rearm", {2'h0, go}, 8'h38);
    endtask : t_trip
    task automatic t_lock();
        lap = 1'b1;
        cyc(2);
        check("lock", {2'h0, go}, 8'h00);
        lap = 1'b0;
        cmd = 3'h0;
        cyc(3);
        check("low", {2'h0, go}, 8'h07);
    endtask : t_lock
    task automatic t_nap();
        na = 1'b0;
        nb = 1'b0;
        sen = 1'b1;
        cyc(SLP + 3);
        check("nap", {brk, cen, go}, 8'h00);
        nb = 1'b1;
        sen = 1'b0;
        cyc(2);
        check("wake", {1'h0, cen, go}, 8'h47);
    endtask : t_nap
    task automatic t_wait_abort();
        nb = 1'h0;
        cyc(2);
        check("wait", {1'h0, cen, go}, 8'h47);
        nb = 1'h1;
        cyc(SLP + 2);
        check("abort", {1'h0, cen, go}, 8'h47);
        na = 1'h1;
    endtask : t_wait_abort
    initial
    begin
        // Gate and break outputs must sit low, comparator enabled, while the controller is still held off
        cyc(8);
        check("rst", {cen, brk, go}, 8'h80);
        rst = 1'b0;
        t_select_off();
        t_trip();
        t_lock();
        t_nap();
        t_wait_abort();
        final_report();
    end
endmodule : tb_top
`default_nettype wire
